//--- rtl/dtc_pkg.sv
// Package for the dual timer/event counter: register selects, field positions,
// mode codes, divider constants and the carrier structs.
// Assumes a CPU core that issues single-cycle register read and write strobes.
package dtc_pkg;

  // ----------------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_CNT0_VALUE = 3'h0;
  localparam logic [2:0] SEL_CNT1_LOW = 3'h1;
  localparam logic [2:0] SEL_CNT1_HIGH = 3'h2;
  localparam logic [2:0] SEL_CNT0_CTRL = 3'h3;
  localparam logic [2:0] SEL_CNT1_CTRL = 3'h4;

  // ----------------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------------
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int RUN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI_BIT = 2;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam int INSTR_DIV = 4;
  localparam int PSC_WIDTH = 7;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } dtc_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } dtc_bus_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] low_buf;
  } dtc_shared_type;

endpackage

//--- rtl/dtc_pin_sync.sv
// Pin synchroniser for a counter input: three stages, change accepted once
// the second and third stages agree; gives rising and falling pulses.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_sync (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
    logic [1:0] warm;
  } dtc_sync_state_type;

  dtc_sync_state_type s_q;
  dtc_sync_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[1:0], pin_i};
    if (s_q.warm != 2'h3) begin
      // Until the chain holds real pin samples, follow it and give no edges
      s_d.warm = s_q.warm + 2'h1;
      s_d.lvl = s_q.sh[1];
    end else if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.lvl = s_q.sh[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.lvl;
  assign rise_o = (s_q.warm == 2'h3) & s_d.lvl & ~s_q.lvl;
  assign fall_o = (s_q.warm == 2'h3) & ~s_d.lvl & s_q.lvl;

endmodule
`default_nettype wire

//--- rtl/dtc_counter.sv
// One counter channel: mode decode, run control, preload, count and overflow.
// Assumes a one-cycle internal tick and synchronised pin edges from the top.
`timescale 1ns/100ps
`default_nettype none
module dtc_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] ctrl_i,
  input wire logic tick_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  output logic [WIDTH-1:0] count_o,
  output logic ovf_o,
  output logic run_clear_o
);

  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("dtc_counter WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] pre;
    logic active;
  } dtc_cnt_state_type;

  dtc_cnt_state_type s_q;
  dtc_cnt_state_type s_d;
  dtc_pkg::dtc_mode_type mode;
  logic run;
  logic edge_sel;
  logic step;
  logic stop;

  always_comb begin
    mode = dtc_pkg::dtc_mode_type'(ctrl_i[dtc_pkg::MODE_HI_BIT:dtc_pkg::MODE_LO_BIT]);
    run = ctrl_i[dtc_pkg::RUN_BIT];
    edge_sel = ctrl_i[dtc_pkg::EDGE_BIT];
    s_d = s_q;
    step = 1'b0;
    stop = 1'b0;
    case (mode)
      dtc_pkg::MODE_TIMER: begin
        step = run & tick_i; // [R1] [R2] [R12] [R14]
      end
      dtc_pkg::MODE_EVENT: begin
        step = run & (edge_sel ? fall_i : rise_i); // [R3] [R4] [R13] [R16]
      end
      dtc_pkg::MODE_PULSE: begin
        // Low edge select: measure a low pulse; high: a high pulse
        if (!run) begin
          s_d.active = 1'b0; // [R18]
        end else if (!s_q.active) begin
          s_d.active = edge_sel ? rise_i : fall_i; // [R19]
        end else if (edge_sel ? fall_i : rise_i) begin
          stop = 1'b1; // [R18]
          s_d.active = 1'b0;
        end else begin
          step = tick_i;
        end
      end
      default: begin
        s_d.active = 1'b0; // [R20]
      end
    endcase
    if (step) begin
      if (s_q.cnt == {WIDTH{1'b1}}) begin
        s_d.cnt = s_q.pre; // [R5] [R7]
      end else begin
        s_d.cnt = s_q.cnt + 1'b1; // [R5]
      end
    end
    if (load_i) begin
      s_d.pre = load_val_i;
      if (!run) begin
        s_d.cnt = load_val_i; // [R6]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.cnt;
  assign ovf_o = step & (s_q.cnt == {WIDTH{1'b1}});
  assign run_clear_o = stop;

endmodule
`default_nettype wire

//--- rtl/dtc_top.sv
// Dual timer/event counter: 8-bit counter with prescaler, 16-bit counter on
// the instruction clock, register port for the CPU core and two pin inputs.
// Assumes the core drives one-cycle read/write strobes with a register select.
//
// Behaviour
// R1: Counter0 internal clock is prescaled system clock
// R2: Counter1 internal clock is system clock over four
// R3: Event mode counts pin edges, no prescaler
// R4: Edge select low rising, high falling
// R5: Count up to all ones, overflow reloads
// R6: Preload write while off loads count too
// R7: Preload write while running waits for overflow
// R8: Low write buffered, high write moves both
// R9: Software writes low byte before high byte
// R10: High read latches low byte for later
// R11: Mode field bits 7:6, 01 event counting
// R12: Bit 4 is run control
// R13: Prescaler ignored when clocked from pin
// R14: Timer advances one per tick, readable
// R15: Interrupt enable bit gates overflow request
// R16: Event counting continues in power down
// R17: Software sets event mode, pin input
// R18: Pulse mode measures pulse, then clears run
// R19: Pulse edge select low falling, high rising
// R20: Modes 00 off, 10 timer, 11 pulse
// R21: Prescale ratio is two to the field
`timescale 1ns/100ps
`default_nettype none
module dtc_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic counter0_int_enable_i,
  input wire logic counter1_int_enable_i,
  input wire logic counter0_value_and_input_i,
  input wire logic counter1_input_pin_i,
  output logic counter0_int_req_o,
  output logic counter1_int_req_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] wr_low_buf;
    logic [7:0] rd_low_buf;
    logic [dtc_pkg::PSC_WIDTH-1:0] psc;
    logic [1:0] quarter;
    logic [7:0] rdata;
    logic irq0;
    logic irq1;
  } dtc_top_state_type;

  dtc_top_state_type s_q;
  dtc_top_state_type s_d;
  dtc_pkg::dtc_bus_type bus;

  logic tick0;
  logic tick1;
  logic lvl0;
  logic rise0;
  logic fall0;
  logic lvl1;
  logic rise1;
  logic fall1;
  logic [7:0] count0;
  logic [15:0] count1;
  logic ovf0;
  logic ovf1;
  logic stop0;
  logic stop1;
  logic load0;
  logic load1;
  logic [15:0] load1_val;

  // Prescaler tick: ratio 2**sel, sel 0 gives every cycle
  function automatic logic psc_tick(input logic [dtc_pkg::PSC_WIDTH-1:0] cnt,
                                    input logic [2:0] sel);
    logic [dtc_pkg::PSC_WIDTH-1:0] mask;
    mask = dtc_pkg::PSC_WIDTH'((8'h01 << sel) - 8'h01);
    return (cnt & mask) == mask;
  endfunction

  assign bus = '{wr: reg_wr_i, rd: reg_rd_i, sel: reg_sel_i, wdata: reg_wdata_i};

  // ----------------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------------
  dtc_pin_sync u_sync0 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(counter0_value_and_input_i),
    .level_o(lvl0),
    .rise_o(rise0),
    .fall_o(fall0)
  );

  dtc_pin_sync u_sync1 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(counter1_input_pin_i),
    .level_o(lvl1),
    .rise_o(rise1),
    .fall_o(fall1)
  );

  // ----------------------------------------------------------------------
  // Clock enables and register loads
  // ----------------------------------------------------------------------
  assign tick0 = psc_tick(s_q.psc, s_q.ctrl0[dtc_pkg::PSC_HI_BIT:0]); // [R1] [R21]
  assign tick1 = (s_q.quarter == 2'(dtc_pkg::INSTR_DIV - 1)); // [R2]
  assign load0 = bus.wr & (bus.sel == dtc_pkg::SEL_CNT0_VALUE);
  assign load1 = bus.wr & (bus.sel == dtc_pkg::SEL_CNT1_HIGH); // [R8]
  assign load1_val = {bus.wdata, s_q.wr_low_buf}; // [R8] [R9]

  dtc_counter #(
    .WIDTH(8)
  ) u_cnt0 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ctrl_i(s_q.ctrl0),
    .tick_i(tick0),
    .rise_i(rise0),
    .fall_i(fall0),
    .load_i(load0),
    .load_val_i(bus.wdata),
    .count_o(count0),
    .ovf_o(ovf0),
    .run_clear_o(stop0)
  );

  dtc_counter #(
    .WIDTH(16)
  ) u_cnt1 (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ctrl_i(s_q.ctrl1),
    .tick_i(tick1),
    .rise_i(rise1),
    .fall_i(fall1),
    .load_i(load1),
    .load_val_i(load1_val),
    .count_o(count1),
    .ovf_o(ovf1),
    .run_clear_o(stop1)
  );

  // ----------------------------------------------------------------------
  // Registers and read path
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.psc = s_q.psc + 1'b1;
    s_d.quarter = s_q.quarter + 1'b1;
    s_d.irq0 = ovf0 & counter0_int_enable_i; // [R15]
    s_d.irq1 = ovf1 & counter1_int_enable_i; // [R15]
    if (bus.wr) begin
      case (bus.sel)
        dtc_pkg::SEL_CNT1_LOW: begin
          s_d.wr_low_buf = bus.wdata; // [R8]
        end
        dtc_pkg::SEL_CNT0_CTRL: begin
          s_d.ctrl0 = bus.wdata; // [R11] [R12]
        end
        dtc_pkg::SEL_CNT1_CTRL: begin
          s_d.ctrl1 = bus.wdata; // [R11] [R12]
        end
        default: begin
        end
      endcase
    end
    // Hardware clear of run comes only in pulse mode; a same-cycle control write wins over it
    if (stop0 && !(bus.wr && bus.sel == dtc_pkg::SEL_CNT0_CTRL)) begin
      s_d.ctrl0[dtc_pkg::RUN_BIT] = 1'b0; // [R18]
    end
    if (stop1 && !(bus.wr && bus.sel == dtc_pkg::SEL_CNT1_CTRL)) begin
      s_d.ctrl1[dtc_pkg::RUN_BIT] = 1'b0; // [R18]
    end
    if (bus.rd) begin
      case (bus.sel)
        dtc_pkg::SEL_CNT0_VALUE: begin
          s_d.rdata = count0; // [R14]
        end
        dtc_pkg::SEL_CNT1_LOW: begin
          s_d.rdata = s_q.rd_low_buf; // [R10]
        end
        dtc_pkg::SEL_CNT1_HIGH: begin
          s_d.rdata = count1[15:8];
          s_d.rd_low_buf = count1[7:0]; // [R10]
        end
        dtc_pkg::SEL_CNT0_CTRL: begin
          s_d.rdata = s_q.ctrl0;
        end
        dtc_pkg::SEL_CNT1_CTRL: begin
          s_d.rdata = s_q.ctrl1;
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
      s_q.ctrl0 <= dtc_pkg::CTRL_RESET;
      s_q.ctrl1 <= dtc_pkg::CTRL_RESET;
      s_q.rdata <= dtc_pkg::VALUE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign counter0_int_req_o = s_q.irq0;
  assign counter1_int_req_o = s_q.irq1;

endmodule
`default_nettype wire

//--- sim/dtc_checker.sv
// Checker: port-level assertions for the dual timer/event counter top.
// Assumes it is bound to dtc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dtc_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic counter0_int_enable_i,
  input wire logic counter1_int_enable_i,
  input wire logic counter0_int_req_o,
  input wire logic counter1_int_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----
  // Mode of counter0 and of counter1 as last written
  // ----
  logic [1:0] mode0_q;
  logic [1:0] mode1_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode0_q <= 2'b00;
      mode1_q <= 2'b00;
    end else begin
      if (reg_wr_i && reg_sel_i == 3'h3) begin
        mode0_q <= reg_wdata_i[7:6];
      end
      if (reg_wr_i && reg_sel_i == 3'h4) begin
        mode1_q <= reg_wdata_i[7:6];
      end
    end
  end
  reset_clear_a: assert property (disable iff (1'b0) srst_i |=> reg_rdata_o == 8'h00
    && !counter0_int_req_o && !counter1_int_req_o) else $error("not clear after reset");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  irq0_gate_a: assert property (!counter0_int_enable_i && !$past(counter0_int_enable_i)
    |-> !counter0_int_req_o) else $error("irq0 while disabled");
  irq1_gate_a: assert property (!counter1_int_enable_i && !$past(counter1_int_enable_i)
    |-> !counter1_int_req_o) else $error("irq1 while disabled");
  irq1_spacing_a: assert property (counter1_int_req_o && mode1_q[1] |=> (!counter1_int_req_o) [*3])
    else $error("irq1 too close");
  off_quiet_a: assert property (mode0_q == 2'b00 && $past(mode0_q) == 2'b00
    |-> !counter0_int_req_o) else $error("irq0 in off mode");
  low_latch_a: assert property ((reg_rd_i && reg_sel_i == 3'h1 && !reg_wr_i)
    ##1 (!reg_rd_i && !reg_wr_i) ##1 (reg_rd_i && reg_sel_i == 3'h1 && !reg_wr_i)
    |=> reg_rdata_o == $past(reg_rdata_o, 2)) else $error("low latch changed");
  ctrl_echo_a: assert property ((reg_wr_i && reg_sel_i == 3'h3) ##1 (!reg_wr_i && !reg_rd_i)
    ##1 (reg_rd_i && reg_sel_i == 3'h3 && !reg_wr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("control readback");
  cover property (counter0_int_req_o);
  cover property (counter1_int_req_o);
  cover property (reg_rd_i && reg_sel_i == 3'h4);
endmodule
bind dtc_top dtc_checker dtc_checker_i (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .counter0_int_enable_i(counter0_int_enable_i),
  .counter1_int_enable_i(counter1_int_enable_i), .counter0_int_req_o(counter0_int_req_o),
  .counter1_int_req_o(counter1_int_req_o));
`default_nettype wire

//--- sim/dtc_pulse_src.sv
// Pulse source: two timer input pins, each leaves its idle level for len_i cycles.
// Assumes one-cycle fire requests; pins rest at idle level between pulses.
`timescale 1ns/100ps
`default_nettype none
module dtc_pulse_src (
  input wire logic clk_i,
  input wire logic [1:0] fire_i,
  input wire logic [7:0] len_i,
  input wire logic [1:0] idle_i,
  output logic [1:0] pin_o
);
  // ----
  // Pulse length counters
  // ----
  logic [7:0] left_q [2] = '{8'h00, 8'h00};
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (fire_i[k]) begin
        left_q[k] <= len_i;
      end else if (left_q[k] != 8'h00) begin
        left_q[k] <= left_q[k] - 8'h01;
      end
    end
  end
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      pin_o[k] = idle_i[k] ^ (left_q[k] != 8'h00);
    end
  end
endmodule
`default_nettype wire

//--- sim/dtc_top_test.sv
// Testbench: drives the register port and pin sources, checks counts and periods.
// Assumes package, design, checker and pulse source are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module dtc_top_test;
  typedef struct {logic ch; logic [7:0] ctrl; logic [15:0] pre; logic en; int per;} dtc_row_type;
  dtc_row_type rows [5] = '{'{0, 8'h90, 16'h00F0, 1, 16}, '{0, 8'h93, 16'h00F0, 1, 128},
    '{0, 8'h97, 16'h00FC, 1, 512}, '{1, 8'h90, 16'hFFF0, 1, 64}, '{0, 8'h90, 16'h00F0, 0, -1}};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [1:0] en = 2'b00;
  wire logic [1:0] irq;
  logic [1:0] fire = 2'b00;
  logic [1:0] pins;
  int err_total = 0;
  int tests_run = 0;
  int n;
  dtc_top dtc_top_i (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_sel_i(sel), .reg_wdata_i(wd), .reg_rdata_o(rdata), .counter0_int_enable_i(en[0]),
    .counter1_int_enable_i(en[1]), .counter0_value_and_input_i(pins[0]),
    .counter1_input_pin_i(pins[1]), .counter0_int_req_o(irq[0]), .counter1_int_req_o(irq[1]));
  dtc_pulse_src dtc_pulse_src_i (.clk_i(clk_i), .fire_i(fire), .len_i(8'h28),
    .idle_i(2'b10), .pin_o(pins));
  // ----
  // Clock, bus tasks and closing
  // ----
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic wreg(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    sel <= s;
    wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] s, output logic [7:0] d);
    @(posedge clk_i);
    rd <= 1'b1;
    sel <= s;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    fire[k] <= 1'b1;
    @(posedge clk_i);
    fire[k] <= 1'b0;
  endtask
  task automatic wait_irq(input logic ch, output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      #1 c++;
    end while (irq[ch] !== 1'b1 && c < 2500);
    if (c >= 2500) c = -1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int s = 0; s < 6; s++) begin
      rreg(s[2:0], v);
      `CHK("reset read", 8'h00, v)
    end
    wreg(3'h3, 8'h13);
    rreg(3'h3, v);
    `CHK("ctrl echo", 8'h13, v)
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk_i);
      en <= {2{rows[i].en}};
      wreg(rows[i].ch ? 3'h4 : 3'h3, 8'h00);
      wreg(rows[i].ch ? 3'h1 : 3'h0, rows[i].pre[7:0]);
      if (rows[i].ch) wreg(3'h2, rows[i].pre[15:8]);
      wreg(rows[i].ch ? 3'h4 : 3'h3, rows[i].ctrl);
      wait_irq(rows[i].ch, n);
      wait_irq(rows[i].ch, n);
      `CHK("period", rows[i].per, n)
    end
    $display("test rows done");
    for (int e = 0; e < 2; e++) begin
      wreg(3'h3, 8'h00);
      wreg(3'h0, 8'hFF);
      rreg(3'h0, v);
      `CHK("off load", 8'hFF, v)
      wreg(3'h3, e ? 8'h5F : 8'h57);
      wreg(3'h0, 8'h20);
      rreg(3'h0, v);
      `CHK("held preload", 8'hFF, v)
      pulse(0);
      repeat (12) @(posedge clk_i);
      rreg(3'h0, v);
      `CHK("edge count", e ? 8'hFF : 8'h20, v)
      repeat (45) @(posedge clk_i);
      rreg(3'h0, v);
      `CHK("reload", 8'h20, v)
    end
    $display("test event done");
    wreg(3'h4, 8'h00);
    wreg(3'h1, 8'h34);
    wreg(3'h2, 8'h12);
    rreg(3'h2, v);
    `CHK("high byte", 8'h12, v)
    rreg(3'h1, v);
    `CHK("low byte", 8'h34, v)
    wreg(3'h1, 8'h00);
    wreg(3'h2, 8'h00);
    wreg(3'h4, 8'hD0);
    pulse(1);
    repeat (60) @(posedge clk_i);
    rreg(3'h4, v);
    `CHK("auto stop", 8'hC0, v)
    pulse(1);
    repeat (60) @(posedge clk_i);
    rreg(3'h2, v);
    `CHK("width high", 8'h00, v)
    rreg(3'h1, v);
    rreg(3'h1, v);
    `CHK("width", 1'b1, v >= 8'h09 && v <= 8'h0B)
    wreg(3'h3, 8'h00);
    wreg(3'h0, 8'h00);
    wreg(3'h3, 8'hD8);
    pulse(0);
    repeat (60) @(posedge clk_i);
    rreg(3'h3, v);
    `CHK("auto stop high", 8'hC8, v)
    rreg(3'h0, v);
    `CHK("width rising", 1'b1, v >= 8'h26 && v <= 8'h28)
    $display("test pulse done");
    wreg(3'h3, 8'h90);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int s = 0; s < 5; s++) begin
      rreg(s[2:0], v);
      `CHK("mid reset read", 8'h00, v)
    end
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
